// ### serial_node_model.sv
// Purpose: Remote serial node that sends frames and records what it hears.
// Assumes: A serial bit lasts bit_time clocks on both sides.
// Notes:   The line idles high between frames.
`timescale 1ns/100ps
`default_nettype none

module serial_node_model (
  // Clock.
  input  wire logic core_clk,
  // Transceiver transmit side.
  input  wire logic serial_tx_pin,
  input  wire logic serial_tx_oe,
  // Line into the transceiver.
  output var  logic serial_rx_pin
);
  int         bit_time = 16;
  int         nbits    = 8;
  bit         par_en   = 1'b0;
  bit         par_odd  = 1'b0;
  logic [8:0] caps[$];
  logic [8:0] shift;

  initial serial_rx_pin = 1'b1;

  task automatic hold_bit(input logic v);
    serial_rx_pin <= v;
    repeat (bit_time) @(posedge core_clk);
  endtask

  // Start, data from the lowest bit, parity, one stop, then idle.
  task automatic send(input logic [8:0] dv, input logic perr, input logic st);
    logic p;
    p = par_odd;
    hold_bit(1'b0);
    for (int i = 0; i < nbits; i++) begin
      hold_bit(dv[i]);
      p = p ^ dv[i];
    end
    if (par_en) hold_bit(p ^ perr);
    hold_bit(st);
    hold_bit(1'b1);
  endtask

  // Records each data field sent while the transmitter drives the pin.
  initial forever begin
    @(negedge serial_tx_pin);
    if (serial_tx_oe) begin
      repeat (bit_time / 2) @(posedge core_clk);
      shift = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_time) @(posedge core_clk);
        shift[i] = serial_tx_pin;
      end
      caps.push_back(shift);
      repeat (bit_time) @(posedge core_clk);
    end
  end
endmodule // serial_node_model
`default_nettype wire

// ### usart_baud_gen.v
// Purpose: Baud prescaler giving one tick per divisor-plus-one clocks.
// Assumes: Divisor and reload pulse come from the register file.
// Notes:   A reload restarts the count at once.
`timescale 1ns/100ps
`default_nettype none
`include "usart_map.vh"

module usart_baud_gen (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Control.
  input  wire [11:0] baud_divisor,
  input  wire        reload,
  // Tick out.
  output reg         tick
);

  reg [11:0] count;

  // Counts down and reloads from the divisor at zero.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      count <= `RST_BAUD;
      tick  <= 1'b0;
    end else if (reload) begin
      count <= baud_divisor;
      tick  <= 1'b0;
    end else if (count == 12'h000) begin
      count <= baud_divisor;
      tick  <= 1'b1;
    end else begin
      count <= count - 12'h001;
      tick  <= 1'b0;
    end
  end

endmodule // usart_baud_gen

`default_nettype wire

// ### usart_map.vh
// Purpose: Register map, field positions and timing constants of the USART.
// Assumes: Included by bare name from the USART design files.
// Notes:   Definitions only.
`ifndef USART_MAP_VH
`define USART_MAP_VH

// Byte offsets on the register bus.
`define OFF_DATA       5'h00
`define OFF_STAT_A     5'h04
`define OFF_STAT_B     5'h08
`define OFF_FRAME      5'h0c
`define OFF_BAUD       5'h10
`define ADDR_HI        7
`define ADDR_LO        5

// Status and control A.
`define A_RXC          7
`define A_TXC          6
`define A_UDRE         5
`define A_FE           4
`define A_DOR          3
`define A_UPE          2
`define A_U2X          1
`define A_MPCM         0

// Status and control B.
`define B_RECEIVE_COMPLETE_IRQ_EN        7
`define B_TRANSMIT_COMPLETE_IRQ_EN        6
`define B_DATA_EMPTY_IRQ_EN        5
`define B_RECEIVER_ENABLE         4
`define B_TRANSMITTER_ENABLE         3
`define B_CSZ2         2
`define B_RXB8         1
`define B_TXB8         0

// Frame configuration.
`define C_MODE_HI      7
`define C_MODE_LO      6
`define C_PAR_HI       5
`define C_PAR_LO       4
`define C_STOP         3
`define C_CSZ_HI       2
`define C_CSZ_LO       1
`define C_POL          0

// Field encodings.
`define MODE_ASYNC     2'h0
`define MODE_SYNC      2'h1
`define PAR_OFF        2'h0
`define PAR_EVEN       2'h2
`define PAR_ODD        2'h3

// Baud ticks per bit.
`define SPB_NORMAL     5'h10
`define SPB_DOUBLE     5'h08
`define SPB_SYNC       5'h02

// Reset values.
`define RST_BYTE       8'h00
`define RST_FRAME      8'h06
`define RST_BAUD       12'h000

// Bus answers.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### usart_register_interface.v
// Purpose: Register file, transmitter and receiver of a serial transceiver.
// Assumes: AXI4-Lite slave on core_clk; serial_rx_pin is asynchronous.
// Notes:   Master SPI mode and the reserved mode leave both engines idle.
//
// Behaviour
// - Data writes go to transmit buffer, reads return receive buffer, masked.
// - Data-empty flag is one after reset; writes while clear are dropped.
// - Enabled transmitter moves buffer into empty shift register, then sends.
// - Receive buffer is a two-entry FIFO popped by every data read.
// - Receive-complete bit 7 shows unread data; cleared by flush.
// - Transmit-complete bit 6 sets after frame with empty buffer; clears.
// - Frame-error bit 4 shows head entry's first stop bit was zero.
// - Overrun bit 3 sets on new start with full FIFO and waiting char.
// - Parity-error bit 2 shows head entry failed enabled parity check.
// - Double speed cuts ticks per bit from 16 to 8, async only.
// - Filter on drops frames lacking address marker; transmitter unaffected.
// - Each interrupt needs its enable, global enable and its flag.
// - Receiver owns rx pin when enabled; disable flushes FIFO and errors.
// - Transmitter drives pin; disable waits until shifter and buffer empty.
// - Mode field 00 async, 01 sync, 11 master SPI, 10 reserved.
// - Parity field 00 off, 10 even, 11 odd; generate and check.
// - Stop select gives one or two transmit stop bits; receiver ignores.
// - Size code 000-011 gives 5-8 bits, 111 nine, both directions.
// - Clock polarity sets sync clock edges, sync mode only.
// - Divisor is 12 bits; low byte write reloads the prescaler.
// - Address marker is first stop bit, or ninth bit for nine-bit frames.
`timescale 1ns/100ps
`default_nettype none
`include "usart_map.vh"

module usart_register_interface (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // AXI4-Lite write address and data.
  input  wire        awvalid,
  output reg         awready,
  input  wire [7:0]  awaddr,
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  // AXI4-Lite write response.
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  // AXI4-Lite read.
  input  wire        arvalid,
  output reg         arready,
  input  wire [7:0]  araddr,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  // Processor interrupt side.
  input  wire        global_irq_en,
  input  wire        tx_complete_irq_ack,
  output reg         irq_receive_complete,
  output reg         irq_transmit_complete,
  output reg         irq_data_empty,
  // Serial pins.
  input  wire        serial_rx_pin,
  output reg         serial_rx_owned,
  output reg         serial_tx_pin,
  output reg         serial_tx_oe,
  output reg         sync_clock_pin,
  output reg         sync_clock_oe
);

  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;
  localparam RX_IDLE = 1'b0;
  localparam RX_RECV = 1'b1;

  // Bus slave state.
  reg        aw_full;
  reg        w_full;
  reg [4:0]  wr_addr;
  reg [31:0] wr_data;
  reg [3:0]  wr_strb;
  reg        next_aw_full;
  reg        next_w_full;
  reg        next_bvalid;
  reg        next_rvalid;
  wire       do_write = aw_full & w_full & ~bvalid;
  wire       do_read  = arvalid & arready;
  wire       wr_ok    = (awaddr[`ADDR_HI:`ADDR_LO] == 3'h0);

  // Registers.
  reg        double_speed;
  reg        multiproc_filter;
  reg        transmit_complete_flag;
  reg        overrun_flag;
  reg [7:0]  serial_status_control_b;
  reg [7:0]  serial_frame_config;
  reg [11:0] baud_divisor;
  reg        baud_reload;
  wire       baud_tick;

  // Transmit path.
  reg        tx_state;
  reg        tx_active;
  reg [8:0]  transmit_buffer;
  reg        tx_buf_valid;
  reg [12:0] tx_shift;
  reg [3:0]  tx_left;
  reg [4:0]  tx_phase;
  reg        tx_done;
  reg [12:0] tx_frame;
  reg [3:0]  tx_len;

  // Receive path.
  reg        rx_meta;
  reg        rx_in;
  reg        rx_state;
  reg [4:0]  rx_phase;
  reg [3:0]  rx_idx;
  reg [10:0] rx_bits;
  reg        rx_done;
  reg [10:0] rx_pend;
  reg        rx_pend_valid;
  reg [10:0] receive_buffer [0:1];
  reg        rx_rd_ptr;
  reg        rx_wr_ptr;
  reg [1:0]  rx_count;

  // Decoded configuration.
  wire [1:0] operating_mode_select = serial_frame_config[`C_MODE_HI:`C_MODE_LO];
  wire [1:0] parity_mode = serial_frame_config[`C_PAR_HI:`C_PAR_LO];
  wire       par_en = parity_mode[1];
  wire       mode_ok = (operating_mode_select == `MODE_ASYNC) |
                       (operating_mode_select == `MODE_SYNC);
  wire       receiver_enable = serial_status_control_b[`B_RECEIVER_ENABLE];
  wire       transmitter_enable = serial_status_control_b[`B_TRANSMITTER_ENABLE];
  wire       transmit_ninth_bit = serial_status_control_b[`B_TXB8];
  wire [2:0] char_size = {serial_status_control_b[`B_CSZ2],
                          serial_frame_config[`C_CSZ_HI:`C_CSZ_LO]};
  reg  [3:0] char_bits;
  reg  [4:0] spb;
  wire [8:0] data_mask = 9'h1ff >> (4'd9 - char_bits);
  wire [4:0] half_bit = spb >> 1;
  wire [3:0] rx_total = char_bits + {3'h0, par_en} + 4'd1;

  // Receive FIFO head and flags.
  wire        rx_has = (rx_count != 2'h0);
  wire [10:0] rx_head = rx_has ? receive_buffer[rx_rd_ptr] : 11'h000;
  wire        rx_pop  = do_read & (araddr == {3'h0, `OFF_DATA}) & rx_has;
  wire        rx_push = rx_pend_valid & ((rx_count != 2'h2) | rx_pop);
  wire        data_empty_flag = ~tx_buf_valid;

  // Receive frame decode.
  wire [8:0] r_data = rx_bits[8:0] & data_mask;
  wire       r_par  = rx_bits[char_bits];
  wire       r_stop = rx_bits[char_bits + {3'h0, par_en}];
  wire       r_mark = (char_bits == 4'd9) ? rx_bits[8] : r_stop;
  wire       r_pe   = par_en & (^r_data ^ parity_mode[0] ^ r_par);

  usart_baud_gen u_baud (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .baud_divisor (baud_divisor),
    .reload       (baud_reload),
    .tick         (baud_tick)
  );

  // Character size and ticks per bit.
  always @* begin
    case (char_size)
      3'h0:    char_bits = 4'd5;
      3'h1:    char_bits = 4'd6;
      3'h2:    char_bits = 4'd7;
      3'h3:    char_bits = 4'd8;
      3'h7:    char_bits = 4'd9;
      default: char_bits = 4'd8;
    endcase
    if (operating_mode_select == `MODE_SYNC)
      spb = `SPB_SYNC;
    else if (double_speed)
      spb = `SPB_DOUBLE;
    else
      spb = `SPB_NORMAL;
  end

  // Builds the outgoing frame, least significant bit first.
  integer i;
  always @* begin
    tx_frame = 13'h1fff;
    tx_frame[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < char_bits)
        tx_frame[i + 1] = transmit_buffer[i];
    end
    if (par_en)
      tx_frame[char_bits + 4'd1] =
        ^(transmit_buffer & data_mask) ^ parity_mode[0];
    tx_len = char_bits + {3'h0, par_en} + 4'd2 +
             {3'h0, serial_frame_config[`C_STOP]};
  end

  // Bus handshake bookkeeping.
  always @* begin
    next_aw_full = (aw_full & ~do_write) | (awvalid & awready);
    next_w_full  = (w_full & ~do_write) | (wvalid & wready);
    next_bvalid  = (bvalid & ~bready) | do_write;
    next_rvalid  = (rvalid & ~rready) | do_read;
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
      bvalid  <= 1'b0;
      rvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rresp   <= `RESP_OKAY;
      rdata   <= 32'h0000_0000;
      wr_addr <= 5'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      bvalid  <= next_bvalid;
      rvalid  <= next_rvalid;
      awready <= ~next_aw_full & ~next_bvalid;
      wready  <= ~next_w_full & ~next_bvalid;
      arready <= ~next_rvalid;
      if (awvalid & awready)
        wr_addr <= wr_ok ? awaddr[4:0] : 5'h1f;
      if (wvalid & wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (do_write)
        bresp <= (wr_addr > `OFF_BAUD || wr_addr[1:0] != 2'h0) ?
                 `RESP_SLVERR : `RESP_OKAY;
      if (do_read) begin
        rresp <= `RESP_OKAY;
        rdata <= 32'h0000_0000;
        case (araddr)
          {3'h0, `OFF_DATA}:
            rdata[8:0] <= {1'b0, rx_head[7:0]};
          {3'h0, `OFF_STAT_A}:
            rdata[7:0] <= {rx_has, transmit_complete_flag, data_empty_flag,
                           rx_head[9], overrun_flag, rx_head[10],
                           double_speed, multiproc_filter};
          {3'h0, `OFF_STAT_B}:
            rdata[7:0] <= {serial_status_control_b[7:2], rx_head[8],
                           transmit_ninth_bit};
          {3'h0, `OFF_FRAME}:
            rdata[7:0] <= serial_frame_config;
          {3'h0, `OFF_BAUD}:
            rdata[15:0] <= {4'h0, baud_divisor};
          default:
            rresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // Register writes and the transmit buffer.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      double_speed            <= 1'b0;
      multiproc_filter        <= 1'b0;
      serial_status_control_b <= `RST_BYTE;
      serial_frame_config     <= `RST_FRAME;
      baud_divisor            <= `RST_BAUD;
      baud_reload             <= 1'b0;
      transmit_buffer         <= 9'h000;
      tx_buf_valid            <= 1'b0;
    end else begin
      baud_reload <= 1'b0;
      if (tx_state == TX_IDLE && tx_active && mode_ok && tx_buf_valid)
        tx_buf_valid <= 1'b0;
      if (do_write && wr_strb[0]) begin
        case (wr_addr)
          `OFF_DATA: begin
            if (data_empty_flag) begin
              transmit_buffer <= {transmit_ninth_bit, wr_data[7:0]};
              tx_buf_valid    <= 1'b1;
            end
          end
          `OFF_STAT_A: begin
            double_speed     <= wr_data[`A_U2X];
            multiproc_filter <= wr_data[`A_MPCM];
          end
          `OFF_STAT_B:
            serial_status_control_b <= {wr_data[7:2],
                                        serial_status_control_b[`B_RXB8],
                                        wr_data[`B_TXB8]};
          `OFF_FRAME:
            serial_frame_config <= wr_data[7:0];
          `OFF_BAUD: begin
            baud_divisor[7:0] <= wr_data[7:0];
            baud_reload       <= 1'b1;
          end
          default: ;
        endcase
      end
      if (do_write && wr_strb[1] && wr_addr == `OFF_BAUD)
        baud_divisor[11:8] <= wr_data[11:8];
    end
  end

  // Transmitter.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state  <= TX_IDLE;
      tx_active <= 1'b0;
      tx_shift  <= 13'h1fff;
      tx_left   <= 4'h0;
      tx_phase  <= 5'h00;
      tx_done   <= 1'b0;
    end else begin
      tx_done   <= 1'b0;
      tx_active <= transmitter_enable |
                   (tx_active & ((tx_state == TX_SEND) | tx_buf_valid));
      case (tx_state)
        TX_IDLE: begin
          if (tx_active && mode_ok && tx_buf_valid) begin
            tx_shift <= tx_frame;
            tx_left  <= tx_len;
            tx_phase <= 5'h00;
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (baud_tick) begin
            if (tx_phase == spb - 5'h01) begin
              tx_phase <= 5'h00;
              tx_shift <= {1'b1, tx_shift[12:1]};
              tx_left  <= tx_left - 4'h1;
              if (tx_left == 4'h1) begin
                tx_state <= TX_IDLE;
                tx_done  <= 1'b1;
              end
            end else begin
              tx_phase <= tx_phase + 5'h01;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Transmit-complete flag; a new completion wins over a clear.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      transmit_complete_flag <= 1'b0;
    end else begin
      if (tx_complete_irq_ack ||
          (do_write && wr_strb[0] && wr_addr == `OFF_STAT_A &&
           wr_data[`A_TXC]))
        transmit_complete_flag <= 1'b0;
      if (tx_done && !tx_buf_valid)
        transmit_complete_flag <= 1'b1;
    end
  end

  // Receiver with pin synchroniser.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_meta       <= 1'b1;
      rx_in         <= 1'b1;
      rx_state      <= RX_IDLE;
      rx_phase      <= 5'h00;
      rx_idx        <= 4'h0;
      rx_bits       <= 11'h000;
      rx_done       <= 1'b0;
      rx_pend       <= 11'h000;
      rx_pend_valid <= 1'b0;
      rx_rd_ptr     <= 1'b0;
      rx_wr_ptr     <= 1'b0;
      rx_count      <= 2'h0;
      overrun_flag  <= 1'b0;
    end else begin
      rx_meta <= serial_rx_pin;
      rx_in   <= rx_meta;
      rx_done <= 1'b0;
      if (!receiver_enable || !mode_ok) begin
        rx_state      <= RX_IDLE;
        rx_pend_valid <= 1'b0;
        rx_count      <= 2'h0;
        rx_rd_ptr     <= 1'b0;
        rx_wr_ptr     <= 1'b0;
        overrun_flag  <= 1'b0;
      end else begin
        if (rx_push) begin
          receive_buffer[rx_wr_ptr] <= rx_pend;
          rx_wr_ptr     <= ~rx_wr_ptr;
          rx_pend_valid <= 1'b0;
        end
        if (rx_pop)
          rx_rd_ptr <= ~rx_rd_ptr;
        rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
        if (do_read && araddr == {3'h0, `OFF_DATA})
          overrun_flag <= 1'b0;
        if (rx_done && !(multiproc_filter && !r_mark)) begin
          rx_pend       <= {r_pe, ~r_stop, r_data};
          rx_pend_valid <= 1'b1;
        end
        case (rx_state)
          RX_IDLE: begin
            if (baud_tick && !rx_in) begin
              rx_state <= RX_RECV;
              rx_phase <= 5'h00;
              rx_idx   <= 4'h0;
              if (rx_pend_valid && rx_count == 2'h2 && !rx_pop)
                overrun_flag <= 1'b1;
            end
          end
          RX_RECV: begin
            if (baud_tick) begin
              rx_phase <= (rx_phase == spb - 5'h01) ? 5'h00 :
                          rx_phase + 5'h01;
              if (rx_phase == half_bit) begin
                rx_idx <= rx_idx + 4'h1;
                if (rx_idx == 4'h0 && rx_in)
                  rx_state <= RX_IDLE;
                if (rx_idx != 4'h0)
                  rx_bits[rx_idx - 4'h1] <= rx_in;
                if (rx_idx == rx_total) begin
                  rx_state <= RX_IDLE;
                  rx_done  <= 1'b1;
                end
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Pin control, synchronous clock and interrupt lines.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      serial_tx_pin         <= 1'b1;
      serial_tx_oe          <= 1'b0;
      serial_rx_owned       <= 1'b0;
      sync_clock_pin        <= 1'b0;
      sync_clock_oe         <= 1'b0;
      irq_receive_complete  <= 1'b0;
      irq_transmit_complete <= 1'b0;
      irq_data_empty        <= 1'b0;
    end else begin
      serial_tx_oe    <= tx_active;
      serial_tx_pin   <= (tx_state == TX_SEND) ? tx_shift[0] : 1'b1;
      serial_rx_owned <= receiver_enable;
      sync_clock_oe   <= (operating_mode_select == `MODE_SYNC) &
                         (tx_active | receiver_enable);
      sync_clock_pin  <= serial_frame_config[`C_POL] ^
                         ((operating_mode_select == `MODE_SYNC) &
                          (tx_state == TX_SEND) &
                          (tx_phase >= half_bit));
      irq_receive_complete  <= global_irq_en & rx_has &
                               serial_status_control_b[`B_RECEIVE_COMPLETE_IRQ_EN];
      irq_transmit_complete <= global_irq_en & transmit_complete_flag &
                               serial_status_control_b[`B_TRANSMIT_COMPLETE_IRQ_EN];
      irq_data_empty        <= global_irq_en & data_empty_flag &
                               serial_status_control_b[`B_DATA_EMPTY_IRQ_EN];
    end
  end

endmodule // usart_register_interface

`default_nettype wire

// ### usart_register_interface_asserts.sv
// Purpose: Port-level checks of the serial transceiver register file.
// Assumes: Bound to every instance of the register file.
// Notes:   Sees bus handshakes, interrupt outputs and the transmit pin.
`timescale 1ns/100ps
`default_nettype none

module usart_register_interface_asserts (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus handshakes.
  input wire logic awvalid, awready, wvalid, wready, bvalid,
  input wire logic arvalid, arready, rvalid,
  // Interrupt side.
  input wire logic global_irq_en, irq_receive_complete,
  input wire logic irq_transmit_complete, irq_data_empty,
  // Transmit pin.
  input wire logic serial_tx_pin, serial_tx_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_write_answer;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write answer missing");
  property p_write_busy; bvalid |-> !awready && !wready; endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("write ready while answering");
  property p_read_answer; arvalid && arready |-> ##[1:2] rvalid; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer missing");
  property p_read_busy; rvalid |-> !arready; endproperty
  a_read_busy: assert property (p_read_busy)
    else $error("read ready while answering");
  property p_irq_rx; !global_irq_en [*2] |-> !irq_receive_complete; endproperty
  a_irq_rx: assert property (p_irq_rx)
    else $error("receive interrupt without global enable");
  property p_irq_tx; !global_irq_en [*2] |-> !irq_transmit_complete; endproperty
  a_irq_tx: assert property (p_irq_tx)
    else $error("transmit interrupt without global enable");
  property p_irq_de; !global_irq_en [*2] |-> !irq_data_empty; endproperty
  a_irq_de: assert property (p_irq_de)
    else $error("empty interrupt without global enable");
  property p_tx_release; $fell(serial_tx_oe) |-> serial_tx_pin; endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("pin released in mid frame");
  property p_tx_start; $fell(serial_tx_pin) |-> serial_tx_oe; endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit on undriven pin");
endmodule // usart_register_interface_asserts

bind usart_register_interface usart_register_interface_asserts
  u_usart_register_interface_asserts (.*);
`default_nettype wire

// ### usart_register_interface_tb.sv
// Purpose: Self-checking bench of the serial transceiver register file.
// Assumes: Divisor 0, so a serial bit lasts 16 clocks.
// Notes:   Bus tasks keep the AXI4-Lite valid and ready rules.
`timescale 1ns/100ps
`default_nettype none
`include "usart_map.vh"

module usart_register_interface_tb;
  // Bus, interrupt and pin signals.
  logic        core_clk = 1'b0, rst_n = 1'b0, bready = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, global_irq_en = 1'b0;
  logic        tx_complete_irq_ack = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        irq_receive_complete, irq_transmit_complete, irq_data_empty;
  logic        serial_rx_pin, serial_rx_owned, serial_tx_pin, serial_tx_oe;
  logic        sync_clock_pin, sync_clock_oe;
  int          err_count = 0, checks_done = 0, cyc = 0;

  usart_register_interface u_usart_register_interface (.*);
  serial_node_model u_serial_node_model (.*);

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      give_verdict;
    end
  end

  task give_verdict;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rchk(`OFF_STAT_A, 8'hff, 8'h20);
    rchk(`OFF_STAT_B, 8'hff, 8'h00);
    rchk(`OFF_FRAME, 8'hff, 8'h06);
    wr(`OFF_BAUD, 32'hf000);
    chk(r, `RESP_OKAY);
    rchk(`OFF_BAUD, 32'hffff, 32'h0);
    rd(8'h14);
    chk(r, `RESP_SLVERR);
    wr(8'h14, 32'h0);
    chk(r, `RESP_SLVERR);
    wr(`OFF_STAT_B, 8'h18);
    wr(`OFF_DATA, 8'ha5);
    wr(`OFF_DATA, 8'h5a);
    wr(`OFF_DATA, 8'hc3);
    repeat (600) @(posedge core_clk);
    chk(serial_rx_owned, 1'b1);
    chk(u_serial_node_model.caps.size(), 2);
    chk(u_serial_node_model.caps[0], 8'ha5);
    chk(u_serial_node_model.caps[1], 8'h5a);
    rchk(`OFF_STAT_A, 8'h40, 8'h40);
    wr(`OFF_STAT_A, 8'h40);
    rchk(`OFF_STAT_A, 8'h40, 8'h00);
    wr(`OFF_STAT_B, 8'h58);
    wr(`OFF_DATA, 8'h11);
    repeat (250) @(posedge core_clk);
    global_irq_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(irq_transmit_complete, 1'b1);
    chk(irq_data_empty, 1'b0);
    tx_complete_irq_ack <= 1'b1;
    @(posedge core_clk);
    tx_complete_irq_ack <= 1'b0;
    rchk(`OFF_STAT_A, 8'h40, 8'h00);
    wr(`OFF_STAT_B, 8'hb8);
    repeat (2) @(posedge core_clk);
    chk(irq_data_empty, 1'b1);
    u_serial_node_model.send(9'h03c, 1'b0, 1'b1);
    chk(irq_receive_complete, 1'b1);
    rchk(`OFF_STAT_A, 8'h80, 8'h80);
    rchk(`OFF_DATA, 8'hff, 8'h3c);
    rchk(`OFF_STAT_A, 8'h80, 8'h00);
    global_irq_en <= 1'b0;
    for (int i = 1; i < 5; i++) u_serial_node_model.send(9'(i), 1'b0, 1'b1);
    rchk(`OFF_STAT_A, 8'h08, 8'h08);
    rchk(`OFF_DATA, 8'hff, 8'h01);
    rchk(`OFF_DATA, 8'hff, 8'h02);
    wr(`OFF_STAT_B, 8'h08);
    rchk(`OFF_STAT_A, 8'h9c, 8'h00);
    wr(`OFF_STAT_B, 8'h18);
    u_serial_node_model.send(9'h077, 1'b0, 1'b0);
    rchk(`OFF_STAT_A, 8'h10, 8'h10);
    rchk(`OFF_DATA, 8'hff, 8'h77);
    rchk(`OFF_STAT_A, 8'h10, 8'h00);
    u_serial_node_model.par_en = 1'b1;
    for (int m = 2; m < 4; m++) begin
      u_serial_node_model.par_odd = m[0];
      wr(`OFF_FRAME, 32'h06 | (m << 4));
      u_serial_node_model.send(9'h055, 1'b1, 1'b1);
      rchk(`OFF_STAT_A, 8'h04, 8'h04);
      rd(`OFF_DATA);
      u_serial_node_model.send(9'h055, 1'b0, 1'b1);
      rchk(`OFF_STAT_A, 8'h84, 8'h80);
      rd(`OFF_DATA);
    end
    u_serial_node_model.par_en = 1'b0;
    u_serial_node_model.nbits = 5;
    u_serial_node_model.bit_time = 8;
    wr(`OFF_STAT_A, 8'h02);
    wr(`OFF_FRAME, 8'h00);
    u_serial_node_model.send(9'h0ff, 1'b0, 1'b1);
    rchk(`OFF_DATA, 8'hff, 8'h1f);
    u_serial_node_model.nbits = 8;
    u_serial_node_model.bit_time = 16;
    wr(`OFF_FRAME, 8'h06);
    wr(`OFF_STAT_A, 8'h01);
    u_serial_node_model.send(9'h012, 1'b0, 1'b0);
    rchk(`OFF_STAT_A, 8'h80, 8'h00);
    u_serial_node_model.send(9'h034, 1'b0, 1'b1);
    rchk(`OFF_DATA, 8'hff, 8'h34);
    wr(`OFF_STAT_B, 8'h1c);
    u_serial_node_model.nbits = 9;
    u_serial_node_model.send(9'h1a5, 1'b0, 1'b1);
    rchk(`OFF_STAT_B, 8'h02, 8'h02);
    rchk(`OFF_DATA, 8'hff, 8'ha5);
    wr(`OFF_STAT_B, 8'h00);
    repeat (4) @(posedge core_clk);
    chk(serial_tx_oe, 1'b0);
    chk(serial_rx_owned, 1'b0);
    give_verdict;
  end
endmodule // usart_register_interface_tb
`default_nettype wire
